// *** sip_fifo.sv ***
// Small valid/ready buffer between the serial decoder and the executor
`timescale 1ns/100ps
`default_nettype none
module sip_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input wire logic clk,                 // System clock
    input wire logic rst_n,               // Async reset, active low
    input wire logic i_valid,             // Write side valid
    output logic o_ready,                 // Write side ready
    input wire logic [WIDTH-1:0] i_data,  // Write side data
    output logic o_valid,                 // Read side valid
    input wire logic i_ready,             // Read side ready
    output logic [WIDTH-1:0] o_data       // Read side data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;
    wire [AW-1:0] wr_ptr_nx = (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
    wire [AW-1:0] rd_ptr_nx = (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;

    assign o_ready = (cnt_q != FULL);
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_nx;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_nx;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fifo_no_over: assert property (cnt_q <= FULL)
        else $error("Buffer count above depth");
    a_fifo_full_ready: assert property (cnt_q == FULL |-> !o_ready)
        else $error("Ready while full");
    a_fifo_keep_head: assert property (o_valid && !i_ready |=>
        o_valid && $stable(o_data))
        else $error("Stalled head changed");
    c_fifo_full: cover property (cnt_q == FULL);
endmodule
`default_nettype wire

// *** sip_isp_port.sv ***
// Serial in-system programming port with program and data memories
//
// Behaviour
// (RULE1) Serial programming only while the device reset pin is held low.
// (RULE2) Programming enable must come first; program and erase ignored before.
// (RULE3) Programmer keeps clock phases over two or three system cycles.
// (RULE4) Incoming data is sampled on the serial clock rising edge.
// (RULE5) Outgoing data is shifted on the serial clock falling edge.
// (RULE6) Programmer pulses reset high if clock could not stay low.
// (RULE7) Programmer waits 20 ms after power-up before enabling; the bench waits about 37 cycles.
// (RULE8) Enable's second byte echoes during third byte; all four bytes sent.
// (RULE9) Missing echo: programmer pulses reset and re-sends enable.
// (RULE10) Programmer loads page bytes with six address bits, low first.
// (RULE11) Page write commits buffered page; 4.5 ms before next access.
// (RULE12) EEPROM byte write auto-erases; 3.6 ms before next byte.
// (RULE13) EEPROM page commit changes only loaded byte locations.
// (RULE14) Chip erase sets all memory to all ones; 9.0 ms wait.
// (RULE15) Busy poll returns status whose low bit is one while busy.
// (RULE16) Decode enable and chip erase on the multi-purpose opcode.
// (RULE17) Decode page byte loads, extended address and EEPROM buffer load.
// (RULE18) Decode memory reads; data returned in the fourth byte.
// (RULE19) Decode lock, fuse, signature and calibration reads.
// (RULE20) Decode program page commit, EEPROM byte and page writes.
// (RULE21) Decode lock and fuse writes on the multi-purpose opcode.
// (RULE22) Program memory uses word addresses; any word selects its page.
// (RULE23) Bytes travel msb first; reply appears during fourth byte.
`timescale 1ns/100ps
`default_nettype none
module sip_isp_port #(
    parameter int PROG_WORDS = 128,
    parameter int EE_BYTES = 32,
    parameter int WD_PROG_CYC = sip_pkg::PROG_PAGE_WRITE_DELAY,
    parameter int WD_EE_CYC = sip_pkg::EEPROM_WRITE_DELAY,
    parameter int WD_ERASE_CYC = sip_pkg::CHIP_ERASE_DELAY,
    parameter logic [7:0] SIG0 = 8'h5a,  // Arbitrary value
    parameter logic [7:0] SIG1 = 8'h01,  // Arbitrary value
    parameter logic [7:0] SIG2 = 8'h02,  // Arbitrary value
    parameter logic [7:0] CAL = 8'h80
) (
    input wire logic I_SYS_CLK,       // System clock
    input wire logic I_RESETN,        // Async system reset, active low
    input wire logic I_RESET_PIN_N,   // Device reset pin, low = programming
    input wire logic I_SCK,           // Serial clock from programmer
    input wire logic I_MOSI,          // Serial data in
    output logic O_MISO,              // Serial data out
    output logic O_MISO_OE_N,         // Data out enable, low = driving
    output logic O_PROG_ENABLED,      // Programming enable accepted
    output logic O_READY_BUSY_FLAG    // Operation pending
);
    localparam int PW = $clog2(PROG_WORDS);
    localparam int EW = $clog2(EE_BYTES);
    localparam int PGW = 1 << sip_pkg::PROG_PAGE_BITS;
    localparam int EPW = 1 << sip_pkg::EE_PAGE_BITS;
    localparam int WW = sip_pkg::WAIT_W;

    function automatic logic f_queued(sip_pkg::sip_instr_t t);
        logic multi;
        multi = (t.op == sip_pkg::OP_MULTI) && (t.b2 != sip_pkg::SUB_ENABLE);
        return multi || t.op == sip_pkg::OP_LD_EXT ||
            t.op == sip_pkg::OP_LD_HI || t.op == sip_pkg::OP_LD_LO ||
            t.op == sip_pkg::OP_EE_LD || t.op == sip_pkg::OP_PG_WR ||
            t.op == sip_pkg::OP_EE_WR || t.op == sip_pkg::OP_EE_PG_WR;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge finding
    logic [2:0] sck_s_q, mosi_s_q, rstp_s_q;
    logic sck_f_q, sck_p_q, mosi_f_q, rstp_f_q;
    wire sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
    wire mosi_f_d = (mosi_s_q[1] == mosi_s_q[2]) ? mosi_s_q[2] : mosi_f_q;
    wire rstp_f_d = (rstp_s_q[1] == rstp_s_q[2]) ? rstp_s_q[2] : rstp_f_q;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sck_s_q <= 3'h0;
            mosi_s_q <= 3'h0;
            rstp_s_q <= 3'h7;
            sck_f_q <= 1'b0;
            sck_p_q <= 1'b0;
            mosi_f_q <= 1'b0;
            rstp_f_q <= 1'b1;
        end else begin
            sck_s_q <= {sck_s_q[1:0], I_SCK};
            mosi_s_q <= {mosi_s_q[1:0], I_MOSI};
            rstp_s_q <= {rstp_s_q[1:0], I_RESET_PIN_N};
            sck_f_q <= sck_f_d;
            sck_p_q <= sck_f_q;
            mosi_f_q <= mosi_f_d;
            rstp_f_q <= rstp_f_d;
        end
    end

    wire prog_mode = ~rstp_f_q;  // RULE1
    wire sck_rise = sck_f_q & ~sck_p_q;
    wire sck_fall = ~sck_f_q & sck_p_q;

    ////////////////////////////////////////////////////////////////////////
    // Serial shifter and reply path
    logic [4:0] bit_cnt_q;
    logic [31:0] rx_q;
    logic [7:0] tx_q, tx_hold_q;
    logic pend_q, enabled_q, busy_q, oe_n_q;
    logic [7:0] ext_q, lock_q, fuse_lo_q, fuse_hi_q, fuse_ext_q;
    wire [31:0] rx_d = {rx_q[30:0], mosi_f_q};  // RULE23
    wire byte_done = prog_mode & sck_rise & (bit_cnt_q[2:0] == 3'h7);
    wire resp_byte = byte_done & (bit_cnt_q[4:3] == 2'h2);
    wire instr_done = byte_done & (bit_cnt_q[4:3] == 2'h3);
    wire [7:0] b1 = rx_d[23:16];
    wire [7:0] b2 = rx_d[15:8];
    wire [7:0] b3 = rx_d[7:0];
    wire sip_pkg::sip_instr_t instr = sip_pkg::sip_instr_t'(rx_d);
    wire is_enable = instr.op == sip_pkg::OP_MULTI &&
        instr.b2 == sip_pkg::SUB_ENABLE;  // RULE16

    // Read decode on the first three bytes
    wire [15:0] pmem [PROG_WORDS];
    wire [7:0] ee [EE_BYTES];
    wire [15:0] rd_waddr = {b2, b3};  // RULE22
    wire pm_hit = (rd_waddr < 16'(PROG_WORDS)) && (ext_q == 8'h00);
    wire [15:0] pm_word = pm_hit ? pmem[rd_waddr[PW-1:0]] :
        sip_pkg::ERASED_WORD;
    wire [9:0] ee_raddr = {b2[1:0], b3};
    wire [7:0] ee_byte = (ee_raddr < 10'(EE_BYTES)) ? ee[ee_raddr[EW-1:0]] :
        sip_pkg::ERASED_BYTE;
    wire alt = (b2 == sip_pkg::SUB_ALT);
    wire [7:0] sig_byte = (b3[1:0] == 2'h0) ? SIG0 :
        (b3[1:0] == 2'h1) ? SIG1 : (b3[1:0] == 2'h2) ? SIG2 :
        sip_pkg::ERASED_BYTE;
    wire busy;
    wire [7:0] resp =
        (b1 == sip_pkg::OP_POLL) ? {7'h00, busy} :               // RULE15
        (b1 == sip_pkg::OP_RD_HI) ? pm_word[15:8] :              // RULE18
        (b1 == sip_pkg::OP_RD_LO) ? pm_word[7:0] :               // RULE18
        (b1 == sip_pkg::OP_EE_RD) ? ee_byte :                    // RULE18
        (b1 == sip_pkg::OP_RD_LOCK) ? (alt ? fuse_hi_q : lock_q) : // RULE19
        (b1 == sip_pkg::OP_RD_FUSE) ? (alt ? fuse_ext_q : fuse_lo_q) :
        (b1 == sip_pkg::OP_RD_SIG) ? sig_byte :                  // RULE19
        (b1 == sip_pkg::OP_RD_CAL) ? CAL : 8'h00;                // RULE19
    wire [7:0] tx_hold_d = resp_byte ? resp : b3;  // RULE8 RULE23

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            bit_cnt_q <= 5'h00;
            rx_q <= 32'h0000_0000;
            enabled_q <= 1'b0;
        end else if (!prog_mode) begin
            bit_cnt_q <= 5'h00;  // RULE1
            enabled_q <= 1'b0;   // RULE1
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            rx_q <= rx_d;  // RULE4
            if (instr_done && is_enable) begin
                enabled_q <= 1'b1;  // RULE2
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_q <= 8'h00;
            tx_hold_q <= 8'h00;
            pend_q <= 1'b0;
        end else if (!prog_mode) begin
            tx_q <= 8'h00;
            pend_q <= 1'b0;
        end else if (byte_done) begin
            tx_hold_q <= tx_hold_d;
            pend_q <= 1'b1;
        end else if (sck_fall) begin
            tx_q <= pend_q ? tx_hold_q : {tx_q[6:0], 1'b0};  // RULE5
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction buffer towards the executor
    logic [WW-1:0] wait_q;
    logic fifo_in_ready, ex_valid;
    logic [31:0] ex_bits;
    wire push = instr_done & enabled_q & f_queued(instr) & fifo_in_ready;
    wire ex_ready = (wait_q == '0);
    wire pop = ex_valid & ex_ready;
    wire sip_pkg::sip_instr_t ex = sip_pkg::sip_instr_t'(ex_bits);

    sip_fifo #(.WIDTH(32), .DEPTH(2)) u_fifo (
        .clk(I_SYS_CLK),
        .rst_n(I_RESETN),
        .i_valid(push),
        .o_ready(fifo_in_ready),
        .i_data(32'(instr)),
        .o_valid(ex_valid),
        .i_ready(ex_ready),
        .o_data(ex_bits)
    );

    assign busy = ex_valid | (wait_q != '0);

    ////////////////////////////////////////////////////////////////////////
    // Executor decode
    wire is_multi = (ex.op == sip_pkg::OP_MULTI);
    wire x_ld_lo = pop & (ex.op == sip_pkg::OP_LD_LO);       // RULE17
    wire x_ld_hi = pop & (ex.op == sip_pkg::OP_LD_HI);       // RULE17
    wire x_ext = pop & (ex.op == sip_pkg::OP_LD_EXT);        // RULE17
    wire x_ee_ld = pop & (ex.op == sip_pkg::OP_EE_LD);       // RULE17
    wire x_pcommit = pop & (ex.op == sip_pkg::OP_PG_WR);     // RULE20
    wire x_ee_wr = pop & (ex.op == sip_pkg::OP_EE_WR);       // RULE20
    wire x_ee_pc = pop & (ex.op == sip_pkg::OP_EE_PG_WR);    // RULE20
    wire x_erase = pop & is_multi & (ex.b2 == sip_pkg::SUB_ERASE); // RULE16
    wire x_lock = pop & is_multi & (ex.b2 == sip_pkg::SUB_WR_LOCK); // RULE21
    wire x_flo = pop & is_multi & (ex.b2 == sip_pkg::SUB_WR_FLO);   // RULE21
    wire x_fhi = pop & is_multi & (ex.b2 == sip_pkg::SUB_WR_FHI);   // RULE21
    wire x_fext = pop & is_multi & (ex.b2 == sip_pkg::SUB_WR_FEXT); // RULE21
    wire [15:0] ex_waddr = {ex.b2, ex.b3};
    wire [9:0] ee_waddr = {ex.b2[1:0], ex.b3};
    wire [sip_pkg::PROG_PAGE_BITS-1:0] pb_idx =
        ex.b3[sip_pkg::PROG_PAGE_BITS-1:0];
    wire [sip_pkg::EE_PAGE_BITS-1:0] eb_idx = ex.b3[sip_pkg::EE_PAGE_BITS-1:0];
    wire [WW-1:0] wait_set = x_pcommit ? WW'(WD_PROG_CYC) :       // RULE11
        (x_ee_wr | x_ee_pc) ? WW'(WD_EE_CYC) :                    // RULE12
        x_erase ? WW'(WD_ERASE_CYC) : '0;                         // RULE14

    logic [7:0] pbuf_lo_q [PGW];
    logic [7:0] pbuf_hi_q [PGW];
    logic [7:0] ebuf_q [EPW];
    logic [EPW-1:0] eload_q;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            wait_q <= '0;
            ext_q <= 8'h00;
            eload_q <= '0;
            lock_q <= sip_pkg::LOCK_RST;
            fuse_lo_q <= sip_pkg::FUSE_LO_RST;
            fuse_hi_q <= sip_pkg::FUSE_HI_RST;
            fuse_ext_q <= sip_pkg::FUSE_EXT_RST;
        end else begin
            wait_q <= pop ? wait_set : (ex_ready ? wait_q : wait_q - 1'b1);
            if (x_ext) begin
                ext_q <= ex.b3;
            end
            if (x_ee_pc) begin
                eload_q <= '0;
            end else if (x_ee_ld) begin
                eload_q[eb_idx] <= 1'b1;  // RULE13
            end
            if (x_erase) begin
                lock_q <= sip_pkg::ERASED_BYTE;
            end else if (x_lock) begin
                lock_q <= ex.dat;
            end
            if (x_flo) begin
                fuse_lo_q <= ex.dat;
            end
            if (x_fhi) begin
                fuse_hi_q <= ex.dat;
            end
            if (x_fext) begin
                fuse_ext_q <= ex.dat;
            end
        end
    end

    // Page buffers; program buffer returns to erased after each commit
    // Reset too, so the first commit writes erased words, not unknowns
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int j = 0; j < PGW; j++) begin
                pbuf_lo_q[j] <= sip_pkg::ERASED_BYTE;
                pbuf_hi_q[j] <= sip_pkg::ERASED_BYTE;
            end
        end else if (x_pcommit) begin
            for (int j = 0; j < PGW; j++) begin
                pbuf_lo_q[j] <= sip_pkg::ERASED_BYTE;
                pbuf_hi_q[j] <= sip_pkg::ERASED_BYTE;
            end
        end else if (x_ld_lo) begin
            pbuf_lo_q[pb_idx] <= ex.dat;
        end else if (x_ld_hi) begin
            pbuf_hi_q[pb_idx] <= ex.dat;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (x_ee_ld) begin
            ebuf_q[eb_idx] <= ex.dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory arrays
    for (genvar i = 0; i < PROG_WORDS; i++) begin : g_pmem
        logic [15:0] w_q;
        localparam int PI = i % PGW;
        wire hit = x_pcommit && (ext_q == 8'h00) &&
            (ex_waddr[15:sip_pkg::PROG_PAGE_BITS] ==
             (16 - sip_pkg::PROG_PAGE_BITS)'(i / PGW));  // RULE22
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                w_q <= sip_pkg::ERASED_WORD;
            end else if (x_erase) begin
                w_q <= sip_pkg::ERASED_WORD;  // RULE14
            end else if (hit) begin
                w_q <= {pbuf_hi_q[PI], pbuf_lo_q[PI]};  // RULE11
            end
        end
        assign pmem[i] = w_q;
    end

    for (genvar i = 0; i < EE_BYTES; i++) begin : g_ee
        logic [7:0] b_q;
        localparam int EI = i % EPW;
        wire byte_hit = x_ee_wr && (ee_waddr == 10'(i));
        wire page_hit = x_ee_pc && eload_q[EI] &&
            (ee_waddr[9:sip_pkg::EE_PAGE_BITS] ==
             (10 - sip_pkg::EE_PAGE_BITS)'(i / EPW));
        always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                b_q <= sip_pkg::ERASED_BYTE;
            end else if (x_erase) begin
                b_q <= sip_pkg::ERASED_BYTE;  // RULE14
            end else if (byte_hit) begin
                b_q <= ex.dat;  // RULE12
            end else if (page_hit) begin
                b_q <= ebuf_q[EI];  // RULE13
            end
        end
        assign ee[i] = b_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            busy_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            busy_q <= busy;
            oe_n_q <= ~prog_mode;
        end
    end

    assign O_MISO = tx_q[7];
    assign O_MISO_OE_N = oe_n_q;
    assign O_PROG_ENABLED = enabled_q;
    assign O_READY_BUSY_FLAG = busy_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    a_leave_mode: assert property (!prog_mode |=> // RULE1
        bit_cnt_q == 5'h00 && !enabled_q)
        else $error("State kept outside programming mode");
    a_gate_enable: assert property (push |-> enabled_q) // RULE2
        else $error("Instruction queued before enable");
    a_sample_rise: assert property (prog_mode && sck_rise |=> // RULE4
        rx_q[0] == $past(mosi_f_q))
        else $error("Data not sampled on rising edge");
    a_shift_fall: assert property ($changed(tx_q) && prog_mode |-> // RULE5
        $past(sck_fall))
        else $error("Output changed off falling edge");
    a_echo_second: assert property (byte_done && // RULE8
        bit_cnt_q[4:3] == 2'h1 |=> tx_hold_q == rx_q[7:0])
        else $error("Second byte not echoed");
    a_poll_status: assert property (resp_byte && // RULE15
        b1 == sip_pkg::OP_POLL |=> tx_hold_q == {7'h00, $past(busy)})
        else $error("Poll status wrong");
    a_commit_wait: assert property (x_pcommit |=> // RULE11
        wait_q == WW'(WD_PROG_CYC) && busy_q ##1 busy_q)
        else $error("Page write delay not started");
    a_erase_fill: assert property (x_erase |=> // RULE14
        pmem[69] == sip_pkg::ERASED_WORD && ee[5] == sip_pkg::ERASED_BYTE)
        else $error("Chip erase left data");
    a_page_keep: assert property (x_ee_pc && !eload_q[2] && // RULE13
        ee_waddr[9:2] == 8'h01 |=> $stable(ee[6]))
        else $error("Unloaded EEPROM byte changed");
    a_ee_byte: assert property (x_ee_wr && ee_waddr == 10'h007 && // RULE12
        !x_erase |=> ee[7] == $past(ex.dat) && wait_q == WW'(WD_EE_CYC))
        else $error("EEPROM byte write wrong");

    c_enable: cover property (instr_done && is_enable);
    c_poll_busy: cover property (resp_byte && b1 == sip_pkg::OP_POLL && busy);
    c_commit: cover property (x_pcommit);
    c_erase: cover property (x_erase);
endmodule
`default_nettype wire

// *** sip_isp_port_test.sv ***
// Self-checking bench for the serial programming port
`timescale 1ns/100ps
`default_nettype none
module sip_isp_port_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sck, mosi, pin_n, miso, oe_n, en, busy;
    logic [31:0] r;
    int fail_count = 0;
    int checks_done = 0;
    wire logic line = oe_n ? ~miso : miso;
    always #25 clk = ~clk;
    sip_isp_port #(.WD_PROG_CYC(20), .WD_EE_CYC(15), .WD_ERASE_CYC(400))
    i_dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_RESET_PIN_N(pin_n),
        .I_SCK(sck), .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE_N(oe_n),
        .O_PROG_ENABLED(en), .O_READY_BUSY_FLAG(busy));
    sip_prog_model i_prog (.clk(clk), .miso(line), .sck(sck), .mosi(mosi),
        .rst_pin_n(pin_n));
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [31:0] c, input logic [7:0] e);
        i_prog.xfer(c, r);
        chk($sformatf("reply %h", c), e, r[7:0]);
    endtask
    task automatic t_enable;
        i_prog.set_pin(1'b0);
        i_prog.xfer(32'hac_e0_00_00, r);
        rd(32'h58_00_00_00, 8'hff);
        chk("enabled", 8'h00, {7'h00, en});
        i_prog.xfer(32'hac_53_00_00, r);
        chk("echo", 8'h53, r[15:8]);
        if (r[15:8] !== 8'h53) begin
            i_prog.set_pin(1'b1);
            i_prog.set_pin(1'b0);
            i_prog.xfer(32'hac_53_00_00, r);
        end
        chk("enabled", 8'h01, {7'h00, en});
        chk("oe_n", 8'h00, {7'h00, oe_n});
        $display("enable test done");
    endtask
    task automatic t_prog;
        i_prog.xfer(32'h4d_00_00_00, r);
        i_prog.xfer(32'h40_00_05_34, r);
        i_prog.xfer(32'h48_00_05_12, r);
        i_prog.xfer(32'h4c_00_45_00, r);
        rd(32'hf0_00_00_00, 8'h00);
        rd(32'h20_00_45_00, 8'h34);
        rd(32'h28_00_45_00, 8'h12);
        rd(32'h20_00_46_00, 8'hff);
        $display("program page test done");
    endtask
    task automatic t_ee;
        i_prog.xfer(32'hc0_00_07_a5, r);
        rd(32'hf0_00_00_00, 8'h00);
        i_prog.xfer(32'hc0_00_07_5a, r);
        rd(32'ha0_00_07_00, 8'h5a);
        i_prog.xfer(32'hc1_00_01_3c, r);
        i_prog.xfer(32'hc2_00_04_00, r);
        rd(32'ha0_00_05_00, 8'h3c);
        rd(32'ha0_00_06_00, 8'hff);
        rd(32'ha0_00_07_00, 8'h5a);
        $display("eeprom test done");
    endtask
    task automatic t_fuse;
        logic [7:0] sub[4] = '{8'ha0, 8'ha8, 8'ha4, 8'he0};
        logic [15:0] rc[4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
        logic [7:0] sig[4] = '{8'h5a, 8'h01, 8'h02, 8'hff};
        for (int i = 0; i < 4; i++) begin
            i_prog.xfer({8'hac, sub[i], 8'h00, 8'(i) + 8'h10}, r);
            rd({rc[i], 16'h0000}, 8'(i) + 8'h10);
            rd({16'h3000, 8'(i), 8'h00}, sig[i]);
        end
        rd(32'h38_00_00_00, 8'h80);
        $display("fuse test done");
    endtask
    task automatic t_erase;
        i_prog.xfer(32'hac_80_00_00, r);
        repeat (2) @(negedge clk);
        chk("busy", 8'h01, {7'h00, busy});
        rd(32'hf0_00_00_00, 8'h01);
        rd(32'hf0_00_00_00, 8'h00);
        rd(32'h20_00_45_00, 8'hff);
        rd(32'ha0_00_05_00, 8'hff);
        i_prog.set_pin(1'b1);
        chk("enabled", 8'h00, {7'h00, en});
        chk("oe_n", 8'h01, {7'h00, oe_n});
        $display("erase and exit test done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_enable;
        t_prog;
        t_ee;
        t_fuse;
        t_erase;
        end_sim;
    end
    // About 11000 cycles expected; three times that
    initial begin
        repeat (33000) @(negedge clk);
        fail_count++;
        end_sim;
    end
endmodule
`default_nettype wire

// *** sip_pkg.sv ***
// Constants and types shared by the serial programming port files
`default_nettype none
package sip_pkg;

    // Instruction opcodes (first byte)
    localparam logic [7:0] OP_MULTI = 8'hac;
    localparam logic [7:0] OP_POLL = 8'hf0;
    localparam logic [7:0] OP_LD_EXT = 8'h4d;
    localparam logic [7:0] OP_LD_HI = 8'h48;
    localparam logic [7:0] OP_LD_LO = 8'h40;
    localparam logic [7:0] OP_EE_LD = 8'hc1;
    localparam logic [7:0] OP_RD_HI = 8'h28;
    localparam logic [7:0] OP_RD_LO = 8'h20;
    localparam logic [7:0] OP_EE_RD = 8'ha0;
    localparam logic [7:0] OP_RD_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_PG_WR = 8'h4c;
    localparam logic [7:0] OP_EE_WR = 8'hc0;
    localparam logic [7:0] OP_EE_PG_WR = 8'hc2;

    // Second-byte selectors
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_WR_LOCK = 8'he0;
    localparam logic [7:0] SUB_WR_FLO = 8'ha0;
    localparam logic [7:0] SUB_WR_FHI = 8'ha8;
    localparam logic [7:0] SUB_WR_FEXT = 8'ha4;
    localparam logic [7:0] SUB_ALT = 8'h08;

    // Memory organisation
    localparam int PROG_PAGE_BITS = 6;
    localparam int EE_PAGE_BITS = 2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // Reset values of the lock and fuse bytes
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;

    // Timing: times in ns, cycle counts derived from the clock period
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_PROG_PAGE_NS = 4500000;
    localparam int T_EE_WRITE_NS = 3600000;
    localparam int T_CHIP_ERASE_NS = 9000000;
    localparam int PROG_PAGE_WRITE_DELAY =
        (T_PROG_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EEPROM_WRITE_DELAY =
        (T_EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHIP_ERASE_DELAY =
        (T_CHIP_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 20;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] dat;
    } sip_instr_t;

endpackage
`default_nettype wire

// *** sip_prog_model.sv ***
// Programmer model driving the serial programming link
`timescale 1ns/100ps
`default_nettype none
module sip_prog_model (
    input wire logic clk,   // System clock
    input wire logic miso,  // Serial data from device
    output logic sck,       // Serial clock, idle low
    output logic mosi,      // Serial data to device
    output logic rst_pin_n  // Device reset pin
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        rst_pin_n = 1'b1;
    end
    task automatic set_pin(input logic v);
        @(negedge clk) rst_pin_n = v;
        repeat (12) @(negedge clk);
    endtask
    // All 32 bits always sent, 450 ns period
    task automatic xfer(input logic [31:0] c, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            @(negedge clk) mosi = c[i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            r = {r[30:0], miso};
            sck = 1'b0;
        end
        @(negedge clk) mosi = ~mosi;
    endtask
endmodule
`default_nettype wire
